// *** hw/pwr_button_pkg.sv ***
`default_nettype none

package pwr_button_pkg;

	// Register byte offsets on the APB word map.
	localparam logic [11:0] CTRL_OFFS      = 12'h000;
	localparam logic [11:0] STATUS_OFFS    = 12'h004;
	localparam logic [11:0] INT_STAT_OFFS  = 12'h008;
	localparam logic [11:0] INT_MASK_OFFS  = 12'h00c;

	// Control register field positions.
	localparam int DEB_SEL_POS    = 0;
	localparam int ON_SEL_POS     = 2;
	localparam int MAX_SEL_POS    = 4;
	localparam int SW_OFF_POS     = 8;
	localparam int CTRL_WIDTH     = 6;

	// Status register field positions.
	localparam int ST_ON_POS      = 0;
	localparam int ST_PRESSED_POS = 1;

	// Event bit positions, shared by the interrupt status and mask registers.
	localparam int EV_OFF_IRQ_POS = 0;
	localparam int EV_DOWN_POS    = 1;
	localparam int EV_UP_POS      = 2;
	localparam int EV_WIDTH       = 3;

	// Reset values.
	localparam logic [CTRL_WIDTH-1:0] CTRL_RST     = 6'h00;
	localparam logic [EV_WIDTH-1:0]   INT_MASK_RST = 3'h0;

	// Clock rate and documented times.
	localparam longint CLK_KHZ   = 250000;
	localparam longint T_50_MS   = 50;
	localparam longint T_100_MS  = 100;
	localparam longint T_500_MS  = 500;
	localparam longint T_5_S     = 5;
	localparam longint T_10_S    = 10;
	localparam longint T_15_S    = 15;

	// Cycle counts derived from the times; the 15 s figure passes two to the thirty-first.
	localparam logic [31:0] CYC_50_MS  = 32'(T_50_MS * CLK_KHZ);
	localparam logic [31:0] CYC_100_MS = 32'(T_100_MS * CLK_KHZ);
	localparam logic [31:0] CYC_500_MS = 32'(T_500_MS * CLK_KHZ);
	localparam logic [31:0] CYC_5_S    = 32'(T_5_S * 1000 * CLK_KHZ);
	localparam logic [31:0] CYC_10_S   = 32'(T_10_S * 1000 * CLK_KHZ);
	localparam logic [31:0] CYC_15_S   = 32'(T_15_S * 1000 * CLK_KHZ);

	// Power state of the supervised system.
	typedef enum logic {
		PWR_OFF,
		PWR_ON
	} pwr_state_e;

	// Software configuration carried as one group.
	typedef struct packed {
		logic [1:0] max_sel;
		logic [1:0] on_sel;
		logic [1:0] deb_sel;
	} ctrl_s;

	// Outgoing power requests, one-cycle pulses.
	typedef struct packed {
		logic up;
		logic down;
	} pwr_req_s;

endpackage

`default_nettype wire

// *** hw/level_sync.sv ***
`timescale 1ns/1ns
`default_nettype none

// Two-stage synchroniser; the first stage feeds only the second.
module level_sync (
	input  wire logic pclk,
	input  wire logic rst_n,
	input  wire logic clk_en,
	input  wire logic d,
	output logic      q
);

	logic meta_q;
	logic meta_d;
	logic q_d;

	// Both stages advance together only while the clock enable is high.
	always_comb begin
		meta_d = clk_en ? d : meta_q;
		q_d    = clk_en ? meta_q : q;
	end

	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= 1'b0;
			q      <= 1'b0;
		end else begin
			meta_q <= meta_d;
			q      <= q_d;
		end
	end

endmodule

`default_nettype wire

// *** hw/power_button_on_off_controller.sv ***
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Debounce and off-to-on: 0/50/100/500 ms.
// - ON: press past debounce raises interrupt.
// - OFF: press past off-to-on powers on.
// - Max hold 5/10/15 s or disabled.
// - Max hold reached issues power-down request.
// - Cold reset ANDed with power-on reset.
module power_button_on_off_controller #(
	parameter logic [31:0] CYC_50_MS  = pwr_button_pkg::CYC_50_MS,
	parameter logic [31:0] CYC_100_MS = pwr_button_pkg::CYC_100_MS,
	parameter logic [31:0] CYC_500_MS = pwr_button_pkg::CYC_500_MS,
	parameter logic [31:0] CYC_5_S    = pwr_button_pkg::CYC_5_S,
	parameter logic [31:0] CYC_10_S   = pwr_button_pkg::CYC_10_S,
	parameter logic [31:0] CYC_15_S   = pwr_button_pkg::CYC_15_S
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        por_n,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        power_button_input,
	output logic             power_on_req,
	output logic             power_down_req,
	output logic             power_is_on,
	output logic             irq
);

	////////////////////////////////////////////////////////////////////////////////////////////
	// Reset and button synchronisation.

	// Either the cold reset pin or the internal power-on reset clears every flop.
	logic rst_n;
	assign rst_n = presetn & por_n;

	logic pressed;

	// The button is asynchronous to pclk, so it passes two stages before any timing.
	level_sync u_sync (
		.pclk   (pclk),
		.rst_n  (rst_n),
		.clk_en (clk_en),
		.d      (power_button_input),
		.q      (pressed)
	);

	////////////////////////////////////////////////////////////////////////////////////////////
	// Threshold selection.

	// Press-duration threshold for a two-bit select; zero fires on the first pressed cycle.
	function automatic logic [31:0] short_thr(input logic [1:0] sel);
		logic [31:0] thr;
		thr = 32'h0000_0000;
		case (sel)
			2'h1:    thr = CYC_50_MS;
			2'h2:    thr = CYC_100_MS;
			2'h3:    thr = CYC_500_MS;
			default: thr = 32'h0000_0000;
		endcase
		return thr;
	endfunction

	// Longest hold time; select zero leaves the timer disabled.
	function automatic logic [31:0] max_thr(input logic [1:0] sel);
		logic [31:0] thr;
		thr = 32'h0000_0000;
		case (sel)
			2'h1:    thr = CYC_5_S;
			2'h2:    thr = CYC_10_S;
			2'h3:    thr = CYC_15_S;
			default: thr = 32'h0000_0000;
		endcase
		return thr;
	endfunction

	pwr_button_pkg::ctrl_s ctrl_q;
	pwr_button_pkg::ctrl_s ctrl_d;
	logic [31:0]           deb_thr;
	logic [31:0]           on_thr;
	logic [31:0]           hold_thr;

	// Thresholds follow the control register at once.
	always_comb begin
		deb_thr  = short_thr(ctrl_q.deb_sel);
		on_thr   = short_thr(ctrl_q.on_sel);
		hold_thr = max_thr(ctrl_q.max_sel);
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Press timing and power state.

	pwr_button_pkg::pwr_state_e state_q;
	pwr_button_pkg::pwr_state_e state_d;
	pwr_button_pkg::pwr_req_s   req_q;
	pwr_button_pkg::pwr_req_s   req_d;
	logic [31:0]                cnt_q;
	logic [31:0]                cnt_d;
	logic                       deb_done_q;
	logic                       deb_done_d;
	logic                       hold_done_q;
	logic                       hold_done_d;
	logic                       wait_rel_q;
	logic                       wait_rel_d;
	logic                       ev_off_irq;
	logic                       sw_off;

	// One press is timed by one counter; each threshold fires at most once per press.
	// After a state change the press that caused it must end before a new one counts,
	// otherwise a held button would bounce the system straight back.
	always_comb begin
		state_d     = state_q;
		req_d       = '0;
		cnt_d       = cnt_q;
		deb_done_d  = deb_done_q;
		hold_done_d = hold_done_q;
		wait_rel_d  = wait_rel_q;
		ev_off_irq  = 1'b0;
		if (!pressed) begin
			cnt_d       = 32'h0000_0000;
			deb_done_d  = 1'b0;
			hold_done_d = 1'b0;
			wait_rel_d  = 1'b0;
		end else if (!wait_rel_q) begin
			if (cnt_q != 32'hffff_ffff) begin
				cnt_d = cnt_q + 32'h0000_0001;
			end
			case (state_q)
				pwr_button_pkg::PWR_ON: begin
					if (!deb_done_q && cnt_q >= deb_thr) begin
						deb_done_d = 1'b1;
						ev_off_irq = 1'b1;
					end
					if (!hold_done_q && hold_thr != 32'h0000_0000 && cnt_q >= hold_thr) begin
						hold_done_d = 1'b1;
						req_d.down  = 1'b1;
						state_d     = pwr_button_pkg::PWR_OFF;
						wait_rel_d  = 1'b1;
					end
				end
				pwr_button_pkg::PWR_OFF: begin
					if (cnt_q >= on_thr) begin
						req_d.up   = 1'b1;
						state_d    = pwr_button_pkg::PWR_ON;
						wait_rel_d = 1'b1;
					end
				end
				default: state_d = pwr_button_pkg::PWR_OFF;
			endcase
		end
		// Software may finish an orderly shutdown after the interrupt.
		if (sw_off && state_q == pwr_button_pkg::PWR_ON && !req_d.down) begin
			req_d.down = 1'b1;
			state_d    = pwr_button_pkg::PWR_OFF;
			wait_rel_d = pressed;
		end
	end

	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q     <= pwr_button_pkg::PWR_OFF;
			req_q       <= '0;
			cnt_q       <= 32'h0000_0000;
			deb_done_q  <= 1'b0;
			hold_done_q <= 1'b0;
			wait_rel_q  <= 1'b0;
		end else if (clk_en) begin
			state_q     <= state_d;
			req_q       <= req_d;
			cnt_q       <= cnt_d;
			deb_done_q  <= deb_done_d;
			hold_done_q <= hold_done_d;
			wait_rel_q  <= wait_rel_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// APB slave and interrupt registers.

	localparam int EVW = pwr_button_pkg::EV_WIDTH;

	logic [EVW-1:0] int_stat_q;
	logic [EVW-1:0] int_stat_d;
	logic [EVW-1:0] int_mask_q;
	logic [EVW-1:0] int_mask_d;
	logic [EVW-1:0] events;
	logic [31:0]    prdata_d;
	logic           pready_d;
	logic           pslverr_d;
	logic           irq_d;
	logic           setup;
	logic           wr_take;
	logic           hit;
	logic [31:0]    rd_val;

	// Ready is raised in the setup cycle so every access completes with no wait state,
	// while read data and ready still come straight from flops.
	always_comb begin
		setup   = psel && !penable;
		wr_take = psel && penable && pready && pwrite;
		events  = '0;
		events[pwr_button_pkg::EV_OFF_IRQ_POS] = ev_off_irq;
		events[pwr_button_pkg::EV_DOWN_POS]    = req_d.down;
		events[pwr_button_pkg::EV_UP_POS]      = req_d.up;
		hit    = 1'b1;
		rd_val = 32'h0000_0000;
		case (paddr)
			pwr_button_pkg::CTRL_OFFS: rd_val[pwr_button_pkg::CTRL_WIDTH-1:0] = ctrl_q;
			pwr_button_pkg::STATUS_OFFS: begin
				rd_val[pwr_button_pkg::ST_ON_POS]      = (state_q == pwr_button_pkg::PWR_ON);
				rd_val[pwr_button_pkg::ST_PRESSED_POS] = pressed;
			end
			pwr_button_pkg::INT_STAT_OFFS: rd_val[EVW-1:0] = int_stat_q;
			pwr_button_pkg::INT_MASK_OFFS: rd_val[EVW-1:0] = int_mask_q;
			default:                       hit = 1'b0;
		endcase
		pready_d  = setup;
		pslverr_d = setup && !hit;
		prdata_d  = (setup && !pwrite) ? rd_val : 32'h0000_0000;
		ctrl_d     = ctrl_q;
		int_mask_d = int_mask_q;
		sw_off     = 1'b0;
		int_stat_d = int_stat_q;
		if (wr_take) begin
			case (paddr)
				pwr_button_pkg::CTRL_OFFS: begin
					ctrl_d = pwdata[pwr_button_pkg::CTRL_WIDTH-1:0];
					sw_off = pwdata[pwr_button_pkg::SW_OFF_POS];
				end
				pwr_button_pkg::INT_STAT_OFFS: int_stat_d = int_stat_q & ~pwdata[EVW-1:0];
				pwr_button_pkg::INT_MASK_OFFS: int_mask_d = pwdata[EVW-1:0];
				default:                       ;
			endcase
		end
		// A new event wins over a clear written in the same cycle.
		int_stat_d = int_stat_d | events;
		irq_d      = |(int_stat_d & int_mask_d);
	end

	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q     <= pwr_button_pkg::CTRL_RST;
			int_mask_q <= pwr_button_pkg::INT_MASK_RST;
			int_stat_q <= '0;
			prdata     <= 32'h0000_0000;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			irq        <= 1'b0;
		end else if (clk_en) begin
			ctrl_q     <= ctrl_d;
			int_mask_q <= int_mask_d;
			int_stat_q <= int_stat_d;
			prdata     <= prdata_d;
			pready     <= pready_d;
			pslverr    <= pslverr_d;
			irq        <= irq_d;
		end
	end

	// Request and state outputs mirror their flops.
	always_comb begin
		power_on_req   = req_q.up;
		power_down_req = req_q.down;
		power_is_on    = (state_q == pwr_button_pkg::PWR_ON);
	end

endmodule

`default_nettype wire

// *** dv/pwr_button_properties.sv ***
`timescale 1ns/1ns
`default_nettype none

// Pin-level checker: power requests must agree with the power state.
module pwr_button_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic por_n,
	input wire logic power_button_input,
	input wire logic power_on_req,
	input wire logic power_down_req,
	input wire logic power_is_on,
	input wire logic irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!(presetn && por_n));

	// Either reset source alone must hold the power state, the power-up request and the interrupt quiet.
	property p_reset; disable iff (1'b0)
		!(presetn && por_n) |-> !power_is_on && !power_on_req && !irq;
	endproperty
	a_reset: assert property (p_reset) else $error("outputs active in reset");
	property p_up_from_off;
		power_on_req |-> !$past(power_is_on) ##1 power_is_on;
	endproperty
	a_up_from_off: assert property (p_up_from_off) else $error("power up not from off");
	property p_up_pulse;
		power_on_req |=> !power_on_req;
	endproperty
	a_up_pulse: assert property (p_up_pulse) else $error("power up request too long");
	property p_down_from_on;
		power_down_req |-> $past(power_is_on) ##1 !power_is_on;
	endproperty
	a_down_from_on: assert property (p_down_from_on) else $error("power down not from on");
	// The sync lags two cycles, so four idle samples rule out a power-up request.
	property p_quiet;
		!power_button_input [*4] |=> !power_on_req;
	endproperty
	a_quiet: assert property (p_quiet) else $error("request without press");
	property p_no_clash;
		!(power_on_req && power_down_req);
	endproperty
	a_no_clash: assert property (p_no_clash) else $error("up and down together");
	property p_on_cause;
		$rose(power_is_on) |-> power_on_req || $past(power_on_req);
	endproperty
	a_on_cause: assert property (p_on_cause) else $error("on without request");
	property p_off_cause;
		$fell(power_is_on) |-> power_down_req || $past(power_down_req);
	endproperty
	a_off_cause: assert property (p_off_cause) else $error("off without request");
endmodule

bind power_button_on_off_controller pwr_button_properties u_props (
	.pclk(pclk), .presetn(presetn), .por_n(por_n), .power_button_input(power_button_input),
	.power_on_req(power_on_req), .power_down_req(power_down_req), .power_is_on(power_is_on), .irq(irq)
);

`default_nettype wire

// *** dv/button_model.sv ***
`timescale 1ns/1ns
`default_nettype none

// Push button held for a set number of cycles; released it is pulled low.
module button_model (
	input wire logic        pclk,
	input wire logic        start,
	input wire logic [15:0] hold,
	output logic            btn
);
	logic [15:0] cnt_q;

	// Count down the press; no bounce is modelled.
	// A plain always block, because the initial value below writes the same counter.
	always @(posedge pclk) begin
		if (start) begin
			cnt_q <= hold;
		end else if (cnt_q != 16'h0000) begin
			cnt_q <= cnt_q - 16'h0001;
		end
	end
	initial cnt_q = 16'h0000;
	assign btn = (cnt_q != 16'h0000);
endmodule

`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ns
`default_nettype none

module tb;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        por_n = 1'b1;
	logic        clk_en = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        btn;
	logic        start = 1'b0;
	logic [15:0] hold = 16'h0000;
	logic        on_req;
	logic        down_req;
	logic        is_on;
	logic        irq;
	logic [31:0] rd;
	logic        err;
	int          miscompares = 0;
	int          check_count = 0;
	int          cycles = 0;
	int          n;
	int          t;
	int          downs = 0;
	int          d0;

	// Small counts keep the run short; the same figures give the expected thresholds.
	localparam logic [31:0] SHORT_1 = 32'h0000_0005;
	localparam logic [31:0] SHORT_2 = 32'h0000_000a;
	localparam logic [31:0] SHORT_3 = 32'h0000_0014;
	localparam logic [31:0] HOLD_1  = 32'h0000_0028;
	localparam logic [31:0] HOLD_2  = 32'h0000_003c;
	localparam logic [31:0] HOLD_3  = 32'h0000_0050;

	// Rows: off-to-on select, press length, power-up due.
	int          rows [6][3] = '{'{0,4,1}, '{1,3,0}, '{1,12,1}, '{2,16,1}, '{3,14,0}, '{3,28,1}};
	int          thr [4] = '{0, SHORT_1, SHORT_2, SHORT_3};

	power_button_on_off_controller #(.CYC_50_MS(SHORT_1), .CYC_100_MS(SHORT_2), .CYC_500_MS(SHORT_3),
		.CYC_5_S(HOLD_1), .CYC_10_S(HOLD_2), .CYC_15_S(HOLD_3)) dut (
		.pclk(pclk), .presetn(presetn), .por_n(por_n), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .power_button_input(btn), .power_on_req(on_req),
		.power_down_req(down_req), .power_is_on(is_on), .irq(irq));
	button_model u_btn (.pclk(pclk), .start(start), .hold(hold), .btn(btn));

	always #2 pclk = ~pclk;
	// Count power-down pulses, and cut a hang short.
	always @(posedge pclk) begin
		cycles++;
		if (down_req === 1'b1) begin
			downs++;
		end
		if (cycles > 20000) begin
			miscompares++;
			finish_test();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Press, note the cycle of any power-up request, then let the release settle.
	task press(input int h);
		start <= 1'b1;
		hold <= 16'(h);
		@(posedge pclk);
		start <= 1'b0;
		n = 0;
		while (n < h + 10 && on_req !== 1'b1) begin
			@(posedge pclk);
			n++;
		end
		repeat (h + 6) @(posedge pclk);
	endtask

	task finish_test();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			t = thr[rows[i][0]];
			apb(1'b1, pwr_button_pkg::CTRL_OFFS, 32'(rows[i][0]) << 2);
			press(rows[i][1]);
			check(32'(n < rows[i][1] + 10 && n > t && n <= t + 5), 32'(rows[i][2]));
			check(32'(is_on), 32'(rows[i][2]));
			apb(1'b1, pwr_button_pkg::CTRL_OFFS, 32'h0000_0100);
		end
		// Debounce interrupt then max-hold power-down in one press; mask passes bit 0 only.
		apb(1'b1, pwr_button_pkg::CTRL_OFFS, 32'h0000_0000);
		press(6);
		apb(1'b1, pwr_button_pkg::INT_MASK_OFFS, 32'h0000_0001);
		apb(1'b1, pwr_button_pkg::INT_STAT_OFFS, 32'h0000_0007);
		apb(1'b1, pwr_button_pkg::CTRL_OFFS, 32'h0000_0011);
		press(50);
		check(32'(is_on), 32'h0000_0000);
		check(32'(irq), 32'h0000_0001);
		apb(1'b0, pwr_button_pkg::INT_STAT_OFFS, 32'h0000_0000);
		check(rd, 32'h0000_0003);
		apb(1'b1, pwr_button_pkg::INT_STAT_OFFS, 32'h0000_0001);
		apb(1'b0, pwr_button_pkg::INT_STAT_OFFS, 32'h0000_0000);
		check(rd, 32'h0000_0002);
		check(32'(irq), 32'h0000_0000);
		// Each max-hold setting: one press just short, one past it; disabled never ends.
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, pwr_button_pkg::CTRL_OFFS, 32'h0000_0000);
			press(6);
			apb(1'b1, pwr_button_pkg::CTRL_OFFS, 32'(m) << 4);
			press(20 * m + 14);
			check(32'(is_on), 32'h0000_0001);
			d0 = downs;
			press(20 * m + 30);
			check(32'(is_on), 32'(m == 0));
			check(32'(downs - d0), 32'(m != 0));
		end
		apb(1'b0, 12'h010, 32'h0000_0000);
		check(32'(err), 32'h0000_0001);
		check(rd, 32'h0000_0000);
		// With the clock enable low, a press that would power up at once is never seen.
		clk_en <= 1'b0;
		press(30);
		clk_en <= 1'b1;
		check(32'(is_on), 32'h0000_0000);
		// Power up first, so that the internal reset alone has a state and a sticky bit to drop.
		press(6);
		apb(1'b0, pwr_button_pkg::STATUS_OFFS, 32'h0000_0000);
		check(rd, 32'h0000_0001);
		por_n <= 1'b0;
		@(posedge pclk);
		check(32'(is_on), 32'h0000_0000);
		check(32'(irq), 32'h0000_0000);
		por_n <= 1'b1;
		apb(1'b0, pwr_button_pkg::CTRL_OFFS, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		finish_test();
	end
endmodule

`default_nettype wire
